// >>> hdl/aes_mode_wrapper.sv
// Purpose: block cipher mode wrapper with byte-wide register port
// Assumes: one write or read strobe per cycle, read data one cycle later
// Notes: the cipher stays locked until a self check passes
`timescale 1ns/1ps
module aes_mode_wrapper
    import aes_wrap_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            done_o,
    output logic            self_check_passed_o
);
    logic         ctr_sel_q;
    logic         cbc_sel_q;
    logic         aes_sel_q;
    logic         self_sel_q;
    logic [2:0]   win_sel_q;
    logic [127:0] key_q;
    logic [127:0] text_q;
    logic [127:0] count_in_q;
    logic [127:0] preload_q;
    logic [127:0] ctr_res_q;
    logic [127:0] acc_q;
    seq_e         state_q;
    logic         core_go_q;
    logic         op_cbc_q;
    logic         op_self_q;
    logic         pass_q;
    logic         done_q;
    logic [7:0]   rdata_q;

    logic         wr_first;
    logic         wr_second;
    logic         wr_status;
    logic         wr_win;
    logic         in_win;
    logic [3:0]   idx;
    logic         launch;
    logic         core_valid;
    logic         finish;
    logic [127:0] core_key;
    logic [127:0] core_text;
    logic [127:0] core_out;
    logic [7:0]   rd_val;

    function automatic logic [7:0] get_byte(input logic [127:0] f, input logic [3:0] i);
        get_byte = 8'(f >> {~i, 3'b000});
    endfunction : get_byte

    function automatic logic [127:0] put_byte(input logic [127:0] f, input logic [3:0] i,
                                              input logic [7:0] b);
        logic [127:0] mask;
        mask     = 128'h000000000000000000000000000000ff << {~i, 3'b000};
        put_byte = (f & ~mask) | (128'(b) << {~i, 3'b000});
    endfunction : put_byte

    assign idx       = addr_i[3:0];
    assign in_win    = (addr_i[7:4] == A_WINDOW_PAGE);
    assign wr_first  = wr_i && addr_i == A_CTRL_FIRST;
    assign wr_second = wr_i && addr_i == A_CTRL_SECOND;
    assign wr_status = wr_i && addr_i == A_EVENT_STATUS;
    assign wr_win    = wr_i && in_win;

    assign launch = wr_first && wdata_i[B_START] && state_q == S_IDLE
                    && (pass_q || wdata_i[B_SELF]);

    assign finish = core_valid && (state_q == S_MAC || (state_q == S_CTR && !op_cbc_q));

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ctr_sel_q  <= 1'b0;
            cbc_sel_q  <= 1'b0;
            aes_sel_q  <= 1'b0;
            self_sel_q <= 1'b0;
        end else if (wr_first) begin
            ctr_sel_q  <= wdata_i[B_CTR];
            cbc_sel_q  <= wdata_i[B_CBC];
            aes_sel_q  <= wdata_i[B_AES];
            self_sel_q <= wdata_i[B_SELF];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            win_sel_q <= SEL_KEY;
        end else if (wr_second) begin
            win_sel_q <= wdata_i[SEL_MSB:SEL_LSB];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            key_q      <= '0;
            text_q     <= '0;
            count_in_q <= '0;
            preload_q  <= '0;
        end else if (wr_win) begin
            case (win_sel_q)
                SEL_KEY:     key_q      <= put_byte(key_q, idx, wdata_i);
                SEL_TEXT:    text_q     <= put_byte(text_q, idx, wdata_i);
                SEL_COUNTER: count_in_q <= put_byte(count_in_q, idx, wdata_i);
                SEL_PRELOAD: preload_q  <= put_byte(preload_q, idx, wdata_i);
                default:     ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_q   <= S_IDLE;
            core_go_q <= 1'b0;
            op_cbc_q  <= 1'b0;
            op_self_q <= 1'b0;
        end else begin
            core_go_q <= 1'b0;
            unique case (state_q)
                S_IDLE: begin
                    if (launch) begin
                        core_go_q <= 1'b1;
                        op_self_q <= wdata_i[B_SELF];
                        op_cbc_q  <= wdata_i[B_CBC] && !wdata_i[B_SELF];
                        state_q   <= (wdata_i[B_CTR] && !wdata_i[B_SELF]) ? S_CTR : S_MAC;
                    end
                end
                S_CTR: begin
                    if (core_valid && op_cbc_q) begin
                        state_q   <= S_MAC;
                        core_go_q <= 1'b1;
                    end else if (core_valid) begin
                        state_q <= S_IDLE;
                    end
                end
                S_MAC: begin
                    if (core_valid) begin
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_comb begin
        core_key  = op_self_q ? acc_q : key_q;
        core_text = text_q;
        if (state_q == S_CTR) begin
            core_text = count_in_q;
        end else if (op_self_q) begin
            core_text = '0;
        end else if (op_cbc_q) begin
            core_text = text_q ^ acc_q;
        end
    end

    aes_core u_core (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (core_go_q),
        .key_i     (core_key),
        .text_i    (core_text),
        .valid_o   (core_valid),
        .done_o    (),
        .out_o     (core_out)
    );

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            ctr_res_q <= '0;
            acc_q     <= '0;
        end else begin
            if (wr_first && wdata_i[B_CLEAR]) begin
                ctr_res_q <= '0;
                acc_q     <= '0;
            end
            if (wr_first && wdata_i[B_PRELOAD]) begin
                acc_q <= preload_q;
            end
            if (core_valid && state_q == S_CTR) begin
                ctr_res_q <= core_out ^ text_q;
            end
            if (core_valid && state_q == S_MAC) begin
                acc_q <= core_out;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pass_q <= 1'b0;
        end else if (core_valid && state_q == S_MAC && op_self_q) begin
            pass_q <= (core_out == SELF_CHECK_RESULT);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
        end else if (wr_status && wdata_i[B_DONE]) begin
            done_q <= 1'b0;
        end
    end

    always_comb begin
        rd_val = BYTE_ZERO;
        if (addr_i == A_CTRL_FIRST) begin
            rd_val[B_CTR]  = ctr_sel_q;
            rd_val[B_CBC]  = cbc_sel_q;
            rd_val[B_AES]  = aes_sel_q;
            rd_val[B_SELF] = self_sel_q;
        end else if (addr_i == A_CTRL_SECOND) begin
            rd_val[SEL_MSB:SEL_LSB] = win_sel_q;
            rd_val[B_PASS]          = pass_q;
        end else if (addr_i == A_EVENT_STATUS) begin
            rd_val[B_DONE] = done_q;
        end else if (in_win && pass_q) begin
            case (win_sel_q)
                SEL_CTR_RES: rd_val = get_byte(ctr_res_q, idx);
                SEL_MAC:     rd_val = get_byte(acc_q, idx);
                SEL_PLAIN:   rd_val = get_byte(acc_q, idx);
                default:     rd_val = BYTE_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rdata_q <= BYTE_ZERO;
        end else begin
            rdata_q <= rd_i ? rd_val : BYTE_ZERO;
        end
    end

    assign rdata_o             = rdata_q;
    assign done_o              = done_q;
    assign self_check_passed_o = pass_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_ctr_result;
        core_valid && state_q == S_CTR |=> ctr_res_q == ($past(core_out) ^ $past(text_q));
    endproperty
    a_ctr_result: assert property (p_ctr_result)
        else $error("counter result not output xor text");

    property p_plain_result;
        core_valid && state_q == S_MAC && !op_cbc_q && !op_self_q |=> acc_q == $past(core_out);
    endproperty
    a_plain_result: assert property (p_plain_result)
        else $error("plain result not stored unchanged");

    property p_done_latency;
        launch && !wdata_i[B_CTR] |-> ##12 finish ##1 done_q;
    endproperty
    a_done_latency: assert property (p_done_latency)
        else $error("completion flag not set twelve cycles after start");

    property p_ccm_order;
        launch && wdata_i[B_CTR] && wdata_i[B_CBC] && !wdata_i[B_SELF]
            |-> ##12 (core_valid && state_q == S_CTR) ##12 (core_valid && state_q == S_MAC);
    endproperty
    a_ccm_order: assert property (p_ccm_order)
        else $error("combined mode did not run counter then chained step");

    property p_busy_ignore;
        state_q != S_IDLE && !core_valid |=> !core_go_q;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("core restarted during a conversion");

    property p_clear;
        wr_first && wdata_i[B_CLEAR] && !wdata_i[B_PRELOAD] && !core_valid
            |=> acc_q == '0 && ctr_res_q == '0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero the result registers");

    property p_preload;
        wr_first && wdata_i[B_PRELOAD] && !core_valid |=> acc_q == $past(preload_q);
    endproperty
    a_preload: assert property (p_preload)
        else $error("accumulator not preloaded");

    property p_locked_read;
        rd_i && in_win && !pass_q |=> rdata_o == BYTE_ZERO;
    endproperty
    a_locked_read: assert property (p_locked_read)
        else $error("result visible before self check passed");

    property p_read_route;
        rd_i && in_win && pass_q && win_sel_q == SEL_CTR_RES
            |=> rdata_o == get_byte($past(ctr_res_q), $past(idx));
    endproperty
    a_read_route: assert property (p_read_route)
        else $error("counter result byte read wrong");

    property p_start_clear;
        rd_i && addr_i == A_CTRL_FIRST |=> !rdata_o[B_START] && rdata_o[B_CTR] == ctr_sel_q;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("start bit not self clearing or mode bit lost");
endmodule : aes_mode_wrapper

// >>> hdl/aes_wrap_pkg.sv
// Purpose: shared constants and types of the cipher mode wrapper
// Assumes: byte-wide register port, one 250 MHz clock
// Notes: window bytes sit at 0x10..0x1f, byte 0 is the most significant
package aes_wrap_pkg;
    // register port addresses
    localparam logic [7:0]   A_CTRL_FIRST      = 8'h00;
    localparam logic [7:0]   A_CTRL_SECOND     = 8'h01;
    localparam logic [7:0]   A_EVENT_STATUS    = 8'h02;
    localparam logic [3:0]   A_WINDOW_PAGE     = 4'h1;
    // cipher_control_first fields
    localparam int           B_START           = 0;
    localparam int           B_CLEAR           = 1;
    localparam int           B_PRELOAD         = 2;
    localparam int           B_CTR             = 3;
    localparam int           B_CBC             = 4;
    localparam int           B_AES             = 5;
    localparam int           B_SELF            = 6;
    // cipher_control_second and event_status_second fields
    localparam int           B_PASS            = 0;
    localparam int           SEL_MSB           = 7;
    localparam int           SEL_LSB           = 5;
    localparam int           B_DONE            = 0;
    // data window selector codes
    localparam logic [2:0]   SEL_KEY           = 3'h0;
    localparam logic [2:0]   SEL_TEXT          = 3'h1;
    localparam logic [2:0]   SEL_COUNTER       = 3'h2;
    localparam logic [2:0]   SEL_CTR_RES       = 3'h3;
    localparam logic [2:0]   SEL_MAC           = 3'h4;
    localparam logic [2:0]   SEL_PRELOAD       = 3'h5;
    localparam logic [2:0]   SEL_PLAIN         = 3'h6;
    // cipher core timing
    localparam logic [3:0]   CORE_CYCLES       = 4'hb;
    localparam logic [3:0]   CIPHER_ROUNDS     = 4'ha;
    localparam logic [7:0]   RCON_FIRST        = 8'h01;
    localparam logic [7:0]   RCON_AFTER_LAST   = 8'h6c;
    // expected core output for zero key and zero text
    localparam logic [127:0] SELF_CHECK_RESULT = 128'h66e94bd4ef8a2c3b884cfa59ca342b2e;
    localparam logic [7:0]   BYTE_ZERO         = 8'h00;

    typedef enum logic [2:0] {
        S_IDLE = 3'h1,
        S_CTR  = 3'h2,
        S_MAC  = 3'h4
    } seq_e;
endpackage : aes_wrap_pkg

// >>> hdl/aes_sbox.sv
// Purpose: forward byte substitution lookup
// Assumes: purely combinational
// Notes: table entry 0 is the leftmost byte
`timescale 1ns/1ps
module aes_sbox (
    input  wire logic [7:0] x_i,
    output logic      [7:0] y_o
);
    localparam logic [0:255][7:0] TABLE = {
        128'h637c777bf26b6fc53001672bfed7ab76, 128'hca82c97dfa5947f0add4a2af9ca472c0,
        128'hb7fd9326363ff7cc34a5e5f171d83115, 128'h04c723c31896059a071280e2eb27b275,
        128'h09832c1a1b6e5aa0523bd6b329e32f84, 128'h53d100ed20fcb15b6acbbe394a4c58cf,
        128'hd0efaafb434d338545f9027f503c9fa8, 128'h51a3408f929d38f5bcb6da2110fff3d2,
        128'hcd0c13ec5f974417c4a77e3d645d1973, 128'h60814fdc222a908846eeb814de5e0bdb,
        128'he0323a0a4906245cc2d3ac629195e479, 128'he7c8376d8dd54ea96c56f4ea657aae08,
        128'hba78252e1ca6b4c6e8dd741f4bbd8b8a, 128'h703eb5664803f60e613557b986c11d9e,
        128'he1f8981169d98e949b1e87e9ce5528df, 128'h8ca1890dbfe6426841992d0fb054bb16
    };

    assign y_o = TABLE[x_i];
endmodule : aes_sbox

// >>> hdl/aes_core.sv
// Purpose: iterative forward block cipher core, one round per clock
// Assumes: start is only given while the core is idle
// Notes: output is valid with valid_o and is held until the next start
`timescale 1ns/1ps
module aes_core
    import aes_wrap_pkg::*;
(
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         start_i,
    input  wire logic [127:0] key_i,
    input  wire logic [127:0] text_i,
    output logic              valid_o,
    output logic              done_o,
    output logic      [127:0] out_o
);
    logic [3:0]   cnt_q;
    logic [127:0] st_q;
    logic [127:0] rk_q;
    logic [7:0]   rcon_q;
    logic [127:0] sub;
    logic [127:0] shifted;
    logic [127:0] mixed;
    logic [127:0] rk_next;
    logic [31:0]  kw_sub;
    logic [7:0]   a0, a1, a2, a3;

    function automatic logic [7:0] xtime(input logic [7:0] b);
        xtime = {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
    endfunction : xtime

    for (genvar i = 0; i < 16; i++) begin : g_sub
        aes_sbox u_sbox (.x_i(st_q[127-8*i -: 8]), .y_o(sub[127-8*i -: 8]));
    end
    for (genvar i = 0; i < 4; i++) begin : g_key
        aes_sbox u_sbox (.x_i(rk_q[31-8*((i+1)%4) -: 8]), .y_o(kw_sub[31-8*i -: 8]));
    end

    always_comb begin
        rk_next[127:96] = rk_q[127:96] ^ kw_sub ^ {rcon_q, 24'h000000};
        rk_next[95:64]  = rk_q[95:64] ^ rk_next[127:96];
        rk_next[63:32]  = rk_q[63:32] ^ rk_next[95:64];
        rk_next[31:0]   = rk_q[31:0] ^ rk_next[63:32];
    end

    always_comb begin
        shifted = '0;
        mixed   = '0;
        a0      = 8'h00;
        a1      = 8'h00;
        a2      = 8'h00;
        a3      = 8'h00;
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < 4; r++) begin
                shifted[127-8*(4*c+r) -: 8] = sub[127-8*(4*((c+r)%4)+r) -: 8];
            end
            a0 = shifted[127-32*c -: 8];
            a1 = shifted[119-32*c -: 8];
            a2 = shifted[111-32*c -: 8];
            a3 = shifted[103-32*c -: 8];
            mixed[127-32*c -: 8] = xtime(a0) ^ xtime(a1) ^ a1 ^ a2 ^ a3;
            mixed[119-32*c -: 8] = a0 ^ xtime(a1) ^ xtime(a2) ^ a2 ^ a3;
            mixed[111-32*c -: 8] = a0 ^ a1 ^ xtime(a2) ^ xtime(a3) ^ a3;
            mixed[103-32*c -: 8] = xtime(a0) ^ a0 ^ a1 ^ a2 ^ xtime(a3);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 4'h0;
        end else if (cnt_q == 4'h0) begin
            cnt_q <= start_i ? 4'h1 : 4'h0;
        end else if (cnt_q == CORE_CYCLES) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            st_q   <= '0;
            rk_q   <= '0;
            rcon_q <= RCON_FIRST;
        end else if (start_i && cnt_q == 4'h0) begin
            st_q   <= text_i ^ key_i;
            rk_q   <= key_i;
            rcon_q <= RCON_FIRST;
        end else if (cnt_q != 4'h0 && cnt_q <= CIPHER_ROUNDS) begin
            st_q   <= ((cnt_q == CIPHER_ROUNDS) ? shifted : mixed) ^ rk_next;
            rk_q   <= rk_next;
            rcon_q <= xtime(rcon_q);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            valid_o <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            valid_o <= (cnt_q == CIPHER_ROUNDS);
            if (start_i && cnt_q == 4'h0) begin
                done_o <= 1'b0;
            end else if (cnt_q == CIPHER_ROUNDS) begin
                done_o <= 1'b1;
            end
        end
    end

    assign out_o = st_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_core_latency;
        start_i && cnt_q == 4'h0 |-> ##11 valid_o;
    endproperty
    a_core_latency: assert property (p_core_latency)
        else $error("core output not valid eleven cycles after start");

    property p_valid_then_done;
        valid_o |=> !valid_o && done_o;
    endproperty
    a_valid_then_done: assert property (p_valid_then_done)
        else $error("valid pulse not single or completion level missing");

    property p_round_count;
        valid_o |-> rcon_q == RCON_AFTER_LAST;
    endproperty
    a_round_count: assert property (p_round_count)
        else $error("round key not updated exactly ten times");
endmodule : aes_core

// >>> verif/aes_mode_wrapper_test.sv
// Purpose: self-checking bench of the cipher mode wrapper
// Assumes: key stays zero, so expectations derive from SELF_CHECK_RESULT
// Notes: text and preload values drawn from a fixed seed
`timescale 1ns/1ps
module aes_mode_wrapper_test;
    import aes_wrap_pkg::*;
    logic         sys_clk_i    = 1'b0;
    logic         sys_rst_i    = 1'b1;
    logic [7:0]   addr_i       = 8'h00;
    logic [7:0]   wdata_i      = 8'h00;
    logic         wr_i         = 1'b0;
    logic         rd_i         = 1'b0;
    logic [7:0]   rdata_o;
    logic         done_o;
    logic         self_check_passed_o;
    int           errors       = 0;
    int           total_checks = 0;
    int           cycles       = 0;
    integer       seed         = 32'hbe45;
    logic [127:0] t;
    logic [127:0] v;
    logic [7:0]   b;

    aes_mode_wrapper dut_u (
        .sys_clk_i           (sys_clk_i),
        .sys_rst_i           (sys_rst_i),
        .addr_i              (addr_i),
        .wdata_i             (wdata_i),
        .wr_i                (wr_i),
        .rd_i                (rd_i),
        .rdata_o             (rdata_o),
        .done_o              (done_o),
        .self_check_passed_o (self_check_passed_o)
    );

    always #2 sys_clk_i = ~sys_clk_i;

    always @(posedge sys_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            finish_test();
        end
    end

    function automatic logic [127:0] ctr_exp(input logic [127:0] txt);
        return SELF_CHECK_RESULT ^ txt;
    endfunction : ctr_exp

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask : rd

    task automatic put(input logic [2:0] s, input logic [127:0] val);
        wr(A_CTRL_SECOND, {s, 5'h00});
        for (int i = 0; i < 16; i++) wr({A_WINDOW_PAGE, 4'(i)}, val[127-8*i -: 8]);
    endtask : put

    task automatic get(input logic [2:0] s, output logic [127:0] val);
        logic [7:0] x;
        wr(A_CTRL_SECOND, {s, 5'h00});
        for (int i = 0; i < 16; i++) begin
            rd({A_WINDOW_PAGE, 4'(i)}, x);
            val[127-8*i -: 8] = x;
        end
    endtask : get

    task automatic run(input logic [7:0] ctl, input int n);
        wr(A_CTRL_FIRST, ctl | 8'h01);
        repeat (n - 2) @(posedge sys_clk_i);
        #1 chk("done early", 128'h0, done_o);
        @(posedge sys_clk_i);
        #1 chk("done", 128'h1, done_o);
        rd(A_EVENT_STATUS, b);
        chk("status flag", 128'h1, b);
        wr(A_EVENT_STATUS, 8'h01);
    endtask : run

    initial begin
        repeat (16) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd(A_CTRL_SECOND, b);
        chk("second control", 128'h0, b);
        get(SEL_MAC, v);
        chk("locked mac", 128'h0, v);
        wr(A_CTRL_FIRST, 8'h21);
        repeat (15) @(posedge sys_clk_i);
        #1 chk("locked done", 128'h0, done_o);
        $display("test locked done");
        run(8'h40, 13);
        chk("pass bit", 128'h1, self_check_passed_o);
        rd(A_CTRL_SECOND, b);
        chk("pass register", {SEL_MAC, 4'h0, 1'b1}, b);
        get(SEL_MAC, v);
        chk("self mac", SELF_CHECK_RESULT, v);
        get(SEL_PLAIN, v);
        chk("self plain", SELF_CHECK_RESULT, v);
        wr(A_CTRL_FIRST, 8'h00);
        wr(A_CTRL_FIRST, 8'h02);
        get(SEL_MAC, v);
        chk("cleared mac", 128'h0, v);
        get(SEL_CTR_RES, v);
        chk("cleared ctr", 128'h0, v);
        put(SEL_KEY, 128'h0);
        put(SEL_COUNTER, 128'h0);
        $display("test self check done");
        for (int k = 0; k < 4; k++) begin
            t = (k == 0) ? '1 : {$random(seed), $random(seed), $random(seed), $random(seed)};
            put(SEL_TEXT, t);
            run(8'h08, 13);
            get(SEL_CTR_RES, v);
            chk("ctr result", ctr_exp(t), v);
            rd(A_CTRL_FIRST, b);
            chk("first control", 128'h08, b);
            get(SEL_MAC, v);
            chk("mac untouched", 128'h0, v);
        end
        $display("test counter done");
        put(SEL_TEXT, 128'h0);
        run(8'h20, 13);
        get(SEL_PLAIN, v);
        chk("plain result", SELF_CHECK_RESULT, v);
        get(SEL_CTR_RES, v);
        chk("ctr kept", ctr_exp(t), v);
        $display("test plain done");
        t = {$random(seed), $random(seed), $random(seed), $random(seed)};
        put(SEL_PRELOAD, t);
        wr(A_CTRL_FIRST, 8'h04);
        put(SEL_TEXT, t);
        run(8'h10, 13);
        get(SEL_MAC, v);
        chk("preload mac", SELF_CHECK_RESULT, v);
        get(SEL_PRELOAD, v);
        chk("preload unreadable", 128'h0, v);
        put(SEL_TEXT, SELF_CHECK_RESULT);
        run(8'h10, 13);
        get(SEL_MAC, v);
        chk("chained mac", SELF_CHECK_RESULT, v);
        $display("test chained done");
        t = {$random(seed), $random(seed), $random(seed), $random(seed)};
        put(SEL_PRELOAD, t);
        wr(A_CTRL_FIRST, 8'h04);
        put(SEL_TEXT, t);
        run(8'h18, 25);
        get(SEL_CTR_RES, v);
        chk("combined ctr", ctr_exp(t), v);
        get(SEL_MAC, v);
        chk("combined mac", SELF_CHECK_RESULT, v);
        $display("test combined done");
        wr(A_CTRL_FIRST, 8'h21);
        wr(A_CTRL_FIRST, 8'h21);
        repeat (9) @(posedge sys_clk_i);
        #1 chk("busy done early", 128'h0, done_o);
        @(posedge sys_clk_i);
        #1 chk("busy done", 128'h1, done_o);
        wr(A_EVENT_STATUS, 8'h01);
        repeat (14) @(posedge sys_clk_i);
        #1 chk("no second done", 128'h0, done_o);
        $display("test busy start done");
        finish_test();
    end
endmodule : aes_mode_wrapper_test
